/* File: common/dmacs_consts.svh */
`ifndef DMACS_CONSTS_SVH
`define DMACS_CONSTS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define DMACS_NCHAN        8
`define DMACS_CH_LSB       4
`define DMACS_OFS_PAD      4'h0
`define DMACS_OFS_CNT      4'h4
`define DMACS_OFS_CTL      4'h8
`define DMACS_ADDR_STAT    8'h80
`define DMACS_ADDR_MASK    8'h84

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define DMACS_CNT_W        10
`define DMACS_PW_LSB       8
`define DMACS_XW_LSB       0
`define DMACS_CTL_EN_BIT   0
`define DMACS_PAD_RST      16'h0000
`define DMACS_CNT_RST      10'h000
`define DMACS_MASK_RST     16'h0000
`define DMACS_RDATA_RST    32'h0000_0000

`endif

/* File: common/dmacs_pkg.sv */
package dmacs_pkg;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } dmacs_bus_st_t;

  typedef logic [15:0] dmacs_word_t;

endpackage

/* File: hw/dmacs_flag.sv */
`timescale 1ns/10ps
`include "dmacs_consts.svh"

module dmacs_flag (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Hardware set, software clear
  input  wire logic set,
  input  wire logic clr,
  output logic      flag
);

  logic flag_ff;
  logic nxt_flag;

  // ----------------------------------------
  // Sticky flag
  // ----------------------------------------
  // Set beats clear so an event in the clearing cycle is kept
  always_comb begin
    nxt_flag = flag_ff;
    if (clr) begin
      nxt_flag = 1'b0;
    end
    if (set) begin
      nxt_flag = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flag_ff <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  assign flag = flag_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_flag_clear_only: assert property (
    @(posedge clk) disable iff (!nrst)
    (flag_ff && !clr) |=> flag_ff)
    else $error("Collision flag dropped without a clear");

  chk_flag_set_wins: assert property (
    @(posedge clk) disable iff (!nrst)
    set |=> flag_ff)
    else $error("Collision flag lost a set");

endmodule // dmacs_flag

/* File: hw/dmacs_chan.sv */
`timescale 1ns/10ps
`include "dmacs_consts.svh"

module dmacs_chan #(
  parameter int CNT_W = `DMACS_CNT_W
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // Software control
  input  wire logic             start,
  input  wire logic             abort,
  input  wire logic [CNT_W-1:0] cnt,
  // Request and transfer strobe
  input  wire logic             req,
  output logic                  active,
  output logic                  xfer
);

  logic             active_ff;
  logic             xfer_ff;
  logic [CNT_W-1:0] rem_ff;
  logic             nxt_active;
  logic             nxt_xfer;
  logic [CNT_W-1:0] nxt_rem;

  // ----------------------------------------
  // Transfer sequencing
  // ----------------------------------------
  always_comb begin
    nxt_active = active_ff;
    nxt_rem    = rem_ff;
    nxt_xfer   = 1'b0;
    if (abort) begin
      nxt_active = 1'b0;
    end else if (start && !active_ff) begin
      nxt_active = 1'b1;
      nxt_rem    = cnt;
    end else if (active_ff && req) begin
      nxt_xfer = 1'b1;
      if (rem_ff == '0) begin
        nxt_active = 1'b0;
      end else begin
        nxt_rem = rem_ff - 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      active_ff <= 1'b0;
      xfer_ff   <= 1'b0;
      rem_ff    <= '0;
    end else begin
      active_ff <= nxt_active;
      xfer_ff   <= nxt_xfer;
      rem_ff    <= nxt_rem;
    end
  end

  assign active = active_ff;
  assign xfer   = xfer_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [CNT_W:0] seen_ff;
  logic [CNT_W:0] load_ff;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      seen_ff <= '0;
      load_ff <= '0;
    end else if (start && !active_ff && !abort) begin
      seen_ff <= '0;
      load_ff <= {1'b0, cnt};
    end else if (xfer_ff) begin
      seen_ff <= seen_ff + 1'b1;
    end
  end

  chk_count_plus_one: assert property (
    @(posedge clk) disable iff (!nrst)
    ($fell(active_ff) && !$past(abort)) |=> seen_ff == load_ff + 1'b1)
    else $error("Transfer total differs from count plus one");

  cov_chan_done: cover property (
    @(posedge clk) disable iff (!nrst)
    $fell(active_ff) && !$past(abort));

endmodule // dmacs_chan

/* File: hw/dmacs_top.sv */
// The register addresses and the Avalon-MM register port were decided locally.
`timescale 1ns/10ps
`include "dmacs_consts.svh"


module dmacs_top #(
  parameter int NCH   = `DMACS_NCHAN,
  parameter int CNT_W = `DMACS_CNT_W
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // Avalon-MM slave
  input  wire logic [7:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  // Channel requests and strobes
  input  wire logic [NCH-1:0]    dma_req,
  output logic      [NCH-1:0]    xfer_pulse,
  output logic      [NCH-1:0]    chan_active,
  // Peripheral write activity
  input  wire logic [NCH-1:0]    dma_per_wr,
  input  wire logic              cpu_per_wr,
  input  wire logic [15:0]       cpu_per_addr,
  // DMA RAM write activity
  input  wire logic [NCH-1:0]    dma_ram_wr,
  input  wire logic [NCH*16-1:0] dma_ram_addr,
  input  wire logic              cpu_ram_wr,
  input  wire logic [15:0]       cpu_ram_addr,
  // Interrupt
  output logic                   irq
);

  localparam int CHW = (NCH > 1) ? $clog2(NCH) : 1;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  dmacs_pkg::dmacs_bus_st_t      state_ff;
  dmacs_pkg::dmacs_bus_st_t      nxt_state;
  logic                          wait_ff;
  logic                          nxt_wait;
  logic [31:0]                   rdata_ff;
  logic [31:0]                   nxt_rdata;
  logic [NCH-1:0][15:0]          pad_ff;
  logic [NCH-1:0][15:0]          nxt_pad;
  logic [NCH-1:0][CNT_W-1:0]     cnt_ff;
  logic [NCH-1:0][CNT_W-1:0]     nxt_cnt;
  logic [15:0]                   mask_ff;
  logic [15:0]                   nxt_mask;
  logic                          irq_ff;
  logic                          nxt_irq;
  logic [CHW-1:0]                ch_idx;
  logic                          in_chan;
  logic                          sel_pad;
  logic                          sel_cnt;
  logic                          sel_ctl;
  logic                          sel_stat;
  logic                          sel_mask;
  logic                          wr_go;
  logic [15:0]                   wr_mask;
  logic [15:0]                   rd_word;
  logic [15:0]                   stat_q;
  logic [15:0]                   stat_clr;
  logic [NCH-1:0]                pcoll;
  logic [NCH-1:0]                xcoll;
  logic [NCH-1:0]                ch_start;
  logic [NCH-1:0]                ch_abort;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  assign ch_idx   = avs_address[`DMACS_CH_LSB +: CHW];
  assign in_chan  = !avs_address[7] && (32'(ch_idx) < NCH);
  assign sel_pad  = in_chan && (avs_address[3:0] == `DMACS_OFS_PAD);
  assign sel_cnt  = in_chan && (avs_address[3:0] == `DMACS_OFS_CNT);
  assign sel_ctl  = in_chan && (avs_address[3:0] == `DMACS_OFS_CTL);
  assign sel_stat = (avs_address == `DMACS_ADDR_STAT);
  assign sel_mask = (avs_address == `DMACS_ADDR_MASK);
  assign wr_go    = (state_ff == dmacs_pkg::BUS_ACK) && avs_write;
  assign wr_mask  = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  // Unmapped addresses read as zero and swallow writes
  always_comb begin
    rd_word = 16'h0000;
    if (sel_pad) begin
      rd_word = pad_ff[ch_idx];
    end else if (sel_cnt) begin
      rd_word = {{(16 - CNT_W){1'b0}}, cnt_ff[ch_idx]};
    end else if (sel_ctl) begin
      rd_word = {15'h0000, chan_active[ch_idx]};
    end else if (sel_stat) begin
      rd_word = stat_q;
    end else if (sel_mask) begin
      rd_word = mask_ff;
    end
  end

  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------
  // One wait cycle per access keeps the read mux off the output path
  always_comb begin
    nxt_state = state_ff;
    nxt_wait  = wait_ff;
    nxt_rdata = rdata_ff;
    unique case (state_ff)
      dmacs_pkg::BUS_IDLE: begin
        if (avs_read || avs_write) begin
          nxt_state = dmacs_pkg::BUS_ACK;
          nxt_wait  = 1'b0;
          if (avs_read) begin
            nxt_rdata = {16'h0000, rd_word};
          end
        end
      end
      dmacs_pkg::BUS_ACK: begin
        nxt_state = dmacs_pkg::BUS_IDLE;
        nxt_wait  = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= dmacs_pkg::BUS_IDLE;
      wait_ff  <= 1'b1;
      rdata_ff <= `DMACS_RDATA_RST;
    end else begin
      state_ff <= nxt_state;
      wait_ff  <= nxt_wait;
      rdata_ff <= nxt_rdata;
    end
  end

  assign avs_waitrequest = wait_ff;
  assign avs_readdata    = rdata_ff;

  // ----------------------------------------
  // Channel registers
  // ----------------------------------------
  // Writes while a channel runs are not blocked; software must avoid them
  always_comb begin
    nxt_pad  = pad_ff;
    nxt_cnt  = cnt_ff;
    nxt_mask = mask_ff;
    if (wr_go && sel_pad) begin
      nxt_pad[ch_idx] = (pad_ff[ch_idx] & ~wr_mask)
                      | (avs_writedata[15:0] & wr_mask);
    end
    if (wr_go && sel_cnt) begin
      nxt_cnt[ch_idx] = (cnt_ff[ch_idx] & ~wr_mask[CNT_W-1:0])
                      | (avs_writedata[CNT_W-1:0] & wr_mask[CNT_W-1:0]);
    end
    if (wr_go && sel_mask) begin
      nxt_mask = (mask_ff & ~wr_mask) | (avs_writedata[15:0] & wr_mask);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int n = 0; n < NCH; n++) begin
        pad_ff[n] <= `DMACS_PAD_RST;
        cnt_ff[n] <= `DMACS_CNT_RST;
      end
      mask_ff <= `DMACS_MASK_RST;
    end else begin
      pad_ff  <= nxt_pad;
      cnt_ff  <= nxt_cnt;
      mask_ff <= nxt_mask;
    end
  end

  // ----------------------------------------
  // Channel control
  // ----------------------------------------
  always_comb begin
    ch_start = '0;
    ch_abort = '0;
    if (wr_go && sel_ctl && avs_byteenable[0]) begin
      ch_start[ch_idx] = avs_writedata[`DMACS_CTL_EN_BIT];
      ch_abort[ch_idx] = !avs_writedata[`DMACS_CTL_EN_BIT];
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_chan
      dmacs_chan #(
        .CNT_W (CNT_W)
      ) u_chan (
        .clk    (clk),
        .nrst   (nrst),
        .start  (ch_start[g]),
        .abort  (ch_abort[g]),
        .cnt    (cnt_ff[g]),
        .req    (dma_req[g]),
        .active (chan_active[g]),
        .xfer   (xfer_pulse[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // Collision detection
  // ----------------------------------------
  // Only exact same-cycle writes to one location count as a collision
  always_comb begin
    stat_clr = '0;
    if (wr_go && sel_stat) begin
      stat_clr = avs_writedata[15:0] & wr_mask;
    end
    for (int n = 0; n < NCH; n++) begin
      pcoll[n] = dma_per_wr[n] && cpu_per_wr
              && (cpu_per_addr == pad_ff[n]);
      xcoll[n] = dma_ram_wr[n] && cpu_ram_wr
              && (cpu_ram_addr == dma_ram_addr[n*16 +: 16]);
    end
  end

  generate
    for (g = 0; g < NCH; g++) begin : g_flag
      dmacs_flag u_pw (
        .clk  (clk),
        .nrst (nrst),
        .set  (pcoll[g]),
        .clr  (stat_clr[`DMACS_PW_LSB + g]),
        .flag (stat_q[`DMACS_PW_LSB + g])
      );
      dmacs_flag u_xw (
        .clk  (clk),
        .nrst (nrst),
        .set  (xcoll[g]),
        .clr  (stat_clr[`DMACS_XW_LSB + g]),
        .flag (stat_q[`DMACS_XW_LSB + g])
      );
    end
    if (NCH < 8) begin : g_pad
      assign stat_q[`DMACS_PW_LSB + 7 : `DMACS_PW_LSB + NCH] = '0;
      assign stat_q[`DMACS_XW_LSB + 7 : `DMACS_XW_LSB + NCH] = '0;
    end
  endgenerate

  // ----------------------------------------
  // Interrupt
  // ----------------------------------------
  assign nxt_irq = |(stat_q & mask_ff);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= nxt_irq;
    end
  end

  assign irq = irq_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  chk_pad_write: assert property (
    (wr_go && sel_pad && avs_byteenable[1:0] == 2'b11)
    |=> pad_ff[$past(ch_idx)] == $past(avs_writedata[15:0]))
    else $error("Peripheral address write not stored");

  chk_cnt_write: assert property (
    (wr_go && sel_cnt && avs_byteenable[1:0] == 2'b11)
    |=> cnt_ff[$past(ch_idx)] == $past(avs_writedata[CNT_W-1:0]))
    else $error("Transfer count write not stored");

  chk_cnt_upper_zero: assert property (
    (state_ff == dmacs_pkg::BUS_IDLE && avs_read && sel_cnt)
    |=> avs_readdata[31:CNT_W] == '0 && !avs_waitrequest)
    else $error("Count register upper bits not zero");

  chk_pw_bit_map: assert property (
    (|pcoll) |=> (stat_q[15:8] & $past(pcoll)) == $past(pcoll))
    else $error("Peripheral collision flag at wrong bit");

  chk_xw_bit_map: assert property (
    (|xcoll) |=> (stat_q[7:0] & $past(xcoll)) == $past(xcoll))
    else $error("RAM collision flag at wrong bit");

  chk_coll_detect: assert property (
    (cpu_per_wr && dma_per_wr[0] && cpu_per_addr == pad_ff[0]) |=> stat_q[8])
    else $error("Peripheral collision on channel 0 missed");

  chk_flag_reset_zero: assert property (
    $rose(nrst) |-> stat_q == 16'h0000)
    else $error("Collision flags not zero after reset");

  chk_bus_answer: assert property (
    (state_ff == dmacs_pkg::BUS_IDLE && (avs_read || avs_write))
    |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("Bus answer not after one wait cycle");

  chk_irq_level: assert property (
    (|(stat_q & mask_ff)) |=> irq)
    else $error("Interrupt missing for unmasked flag");

  cov_pad_write: cover property (wr_go && sel_pad);
  cov_coll_set: cover property ($rose(stat_q[8]));
  cov_set_clr_same: cover property (|(pcoll & stat_clr[15:8]));

endmodule // dmacs_top

/* File: verification/dmacs_far_model.sv */
`timescale 1ns/10ps

module dmacs_far_model (
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   nrst,
  // Channels allowed to request
  input  wire logic [7:0]   req_en,
  // Requests
  output logic [7:0]   dma_req,
  // Peripheral writes
  output logic [7:0]   dma_per_wr,
  output logic         cpu_per_wr,
  output logic [15:0]  cpu_per_addr,
  // RAM writes
  output logic [7:0]   dma_ram_wr,
  output logic [127:0] dma_ram_addr,
  output logic         cpu_ram_wr,
  output logic [15:0]  cpu_ram_addr
);
  initial begin
    dma_per_wr   = 8'h00;
    cpu_per_wr   = 1'b0;
    cpu_per_addr = 16'h5a5a;
    dma_ram_wr   = 8'h00;
    dma_ram_addr = {4{32'h3c96_a5c3}};
    cpu_ram_wr   = 1'b0;
    cpu_ram_addr = 16'ha5a5;
  end

  // Random gaps so the channel sees both prompt and stalled requests
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dma_req <= 8'h00;
    end else begin
      dma_req <= req_en & 8'($urandom);
    end
  end

  // One-cycle write from DMA and CPU; released addresses show the inverse
  task automatic collide(input logic ram, input int ch, input logic [15:0] da,
                         input logic [15:0] ca);
    @(posedge clk);
    if (ram) begin
      dma_ram_wr[ch]            <= 1'b1;
      dma_ram_addr[ch*16 +: 16] <= da;
      cpu_ram_wr                <= 1'b1;
      cpu_ram_addr              <= ca;
    end else begin
      dma_per_wr[ch] <= 1'b1;
      cpu_per_wr     <= 1'b1;
      cpu_per_addr   <= ca;
    end
    @(posedge clk);
    dma_ram_wr                <= 8'h00;
    dma_per_wr                <= 8'h00;
    cpu_per_wr                <= 1'b0;
    cpu_ram_wr                <= 1'b0;
    cpu_per_addr              <= ~ca;
    cpu_ram_addr              <= ~ca;
    dma_ram_addr[ch*16 +: 16] <= ~da;
  endtask
endmodule // dmacs_far_model

/* File: verification/test_dma_channel_addr_count_status.sv */
`timescale 1ns/10ps
`include "dmacs_consts.svh"

module test_dma_channel_addr_count_status;
  logic         clk, nrst, avs_read, avs_write, avs_waitrequest, irq;
  logic         cpu_per_wr, cpu_ram_wr;
  logic [7:0]   avs_address, dma_req, xfer_pulse, chan_active, dma_per_wr, dma_ram_wr;
  logic [7:0]   req_en;
  logic [31:0]  avs_writedata, avs_readdata;
  logic [3:0]   avs_byteenable;
  logic [127:0] dma_ram_addr;
  logic [15:0]  cpu_per_addr, cpu_ram_addr, d, e, b;
  logic [9:0]   cnts [4];
  int           error_cnt, checks_done, cycles, pulses, cur_ch;

  dmacs_top dut (
    .clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .dma_req, .xfer_pulse,
    .chan_active, .dma_per_wr, .cpu_per_wr, .cpu_per_addr, .dma_ram_wr,
    .dma_ram_addr, .cpu_ram_wr, .cpu_ram_addr, .irq
  );

  dmacs_far_model fm (
    .clk, .nrst, .req_en, .dma_req, .dma_per_wr, .cpu_per_wr, .cpu_per_addr,
    .dma_ram_wr, .dma_ram_addr, .cpu_ram_wr, .cpu_ram_addr
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ----------------------------------------
  // Expectations
  // ----------------------------------------
  function automatic logic [7:0] adr(input int ch, input logic [3:0] ofs);
    return {4'(ch), ofs};
  endfunction

  function automatic logic [15:0] col_bit(input logic ram, input int ch);
    return ram ? (16'h0001 << `DMACS_XW_LSB + ch) : (16'h0001 << `DMACS_PW_LSB + ch);
  endfunction

  // ----------------------------------------
  // Bus and checking
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Always idles one edge first, so no signal is set twice in one step
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] wd,
                     input logic [3:0] be, output logic [31:0] q);
    @(posedge clk);
    avs_address    <= a;
    avs_read       <= !w;
    avs_write      <= w;
    avs_writedata  <= {16'h0000, wd};
    avs_byteenable <= be;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] wd, input logic [3:0] be);
    logic [31:0] q;
    bus(1'b1, a, wd, be, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 16'h0000, 4'h0, q);
    chk(q, {16'h0000, exp});
  endtask

  task automatic final_report;
    if (error_cnt == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      error_cnt++;
      final_report();
    end
  end

  always @(posedge clk) if (xfer_pulse[cur_ch] === 1'b1) pulses++;

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    nrst = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'h0;
    req_en = 8'h00;
    error_cnt = 0;
    checks_done = 0;
    cycles = 0;
    pulses = 0;
    cur_ch = 0;
    void'($urandom(32'h7c55));
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    for (int ch = 0; ch < 8; ch++) begin
      rd_chk(adr(ch, `DMACS_OFS_PAD), 16'h0000);
      rd_chk(adr(ch, `DMACS_OFS_CNT), 16'h0000);
    end
    rd_chk(`DMACS_ADDR_STAT, 16'h0000);
    rd_chk(8'hfc, 16'h0000);
    // Full and high-lane writes; all channels idle here
    for (int ch = 0; ch < 8; ch++) begin
      d = 16'($urandom);
      e = 16'($urandom);
      wr(adr(ch, `DMACS_OFS_PAD), d, 4'hf);
      rd_chk(adr(ch, `DMACS_OFS_PAD), d);
      wr(adr(ch, `DMACS_OFS_PAD), e, 4'h2);
      rd_chk(adr(ch, `DMACS_OFS_PAD), {e[15:8], d[7:0]});
      wr(adr(ch, `DMACS_OFS_CNT), e, 4'hf);
      rd_chk(adr(ch, `DMACS_OFS_CNT), e & 16'h03ff);
    end
    // Transfer counts at both ends of the field; idle channels see requests too
    cnts = '{10'h000, 10'h001, 10'h3ff, 10'($urandom_range(2, 40))};
    req_en <= 8'hff;
    foreach (cnts[i]) begin
      cur_ch = $urandom_range(0, 7);
      wr(adr(cur_ch, `DMACS_OFS_CNT), {6'h3f, cnts[i]}, 4'hf);
      pulses = 0;
      wr(adr(cur_ch, `DMACS_OFS_CTL), 16'h0001, 4'h1);
      do @(posedge clk); while (chan_active[cur_ch] !== 1'b0);
      repeat (6) @(posedge clk);
      chk(32'(pulses), 32'(cnts[i]) + 32'h1);
    end
    req_en <= 8'h00;
    // Start while running is ignored, then abort; no requests so the channel waits
    wr(adr(2, `DMACS_OFS_CNT), 16'h0005, 4'hf);
    wr(adr(2, `DMACS_OFS_CTL), 16'h0001, 4'h1);
    rd_chk(adr(2, `DMACS_OFS_CTL), 16'h0001);
    wr(adr(2, `DMACS_OFS_CTL), 16'h0001, 4'h1);
    rd_chk(adr(2, `DMACS_OFS_CTL), 16'h0001);
    wr(adr(2, `DMACS_OFS_CTL), 16'h0000, 4'h1);
    rd_chk(adr(2, `DMACS_OFS_CTL), 16'h0000);
    // Collisions on every flag: near miss, hit, write-zero, mask, clear
    for (int k = 0; k < 2; k++) begin
      for (int ch = 0; ch < 8; ch++) begin
        d = 16'($urandom);
        b = col_bit(k[0], ch);
        wr(adr(ch, `DMACS_OFS_PAD), d, 4'hf);
        fm.collide(k[0], ch, d, d ^ 16'h0001);
        rd_chk(`DMACS_ADDR_STAT, 16'h0000);
        fm.collide(k[0], ch, d, d);
        rd_chk(`DMACS_ADDR_STAT, b);
        chk({31'h0, irq}, 32'h0);
        wr(`DMACS_ADDR_STAT, ~b, 4'h3);
        rd_chk(`DMACS_ADDR_STAT, b);
        wr(`DMACS_ADDR_MASK, b, 4'h3);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        // Clear and a fresh collision in one cycle: the collision must win
        fork
          wr(`DMACS_ADDR_STAT, b, 4'h3);
          begin
            @(posedge clk);
            fm.collide(k[0], ch, d, d);
          end
        join
        rd_chk(`DMACS_ADDR_STAT, b);
        wr(`DMACS_ADDR_STAT, b, 4'h3);
        rd_chk(`DMACS_ADDR_STAT, 16'h0000);
        chk({31'h0, irq}, 32'h0);
        wr(`DMACS_ADDR_MASK, 16'h0000, 4'h3);
      end
    end
    final_report();
  end
endmodule // test_dma_channel_addr_count_status
